// ### core/cmc_core.sv
// Control logic of a coax attachment unit: transmit gating, receive loopback,
// jabber lockup, collision burst and heartbeat. Assumes analog front end
// delivers logic levels; all pin inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module cmc_core
    import cmc_pkg::*;
#(
    parameter int JAB_ACT_CYCLES = JAB_ACT_CYC,
    parameter int JAB_REC_CYCLES = JAB_REC_CYC,
    parameter int FIFO_DEPTH     = TXF_DEPTH
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Transmit pair from station, after squelch
    input  wire logic       tx_active_in,
    input  wire logic       tx_data_in,
    // Cable side
    input  wire logic       cable_sense_in,
    input  wire logic       cable_activity_in,
    input  wire logic       coll_below_thresh_in,
    input  wire logic       cable_disconnect_in,
    input  wire logic       drive_ready_in,
    output logic            cable_drive_out,
    // Straps: bit 0 heartbeat enable, bit 1 jabber disable
    input  wire logic [1:0] heartbeat_jabber_strap_in,
    // Pairs toward the station
    output logic            receive_to_station_p_out,
    output logic            receive_to_station_n_out,
    output logic            collision_out_p_out,
    output logic            collision_out_n_out,
    // Status
    output logic            tx_fifo_ready_out,
    output logic            jabber_lock_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [NSYNC-1:0]     sync_a;
        logic [NSYNC-1:0]     sync_b;
        logic [NSYNC-1:0]     sync_c;
        logic [NSYNC-1:0]     filt;
        logic                 tx_on;
        logic                 tx_dat;
        logic [JAB_CNT_W-1:0] jab_cnt;
        logic                 jabbed;
        logic [JAB_CNT_W-1:0] rec_cnt;
        cmc_hb_t              hb;
        logic [HB_CNT_W-1:0]  hb_cnt;
        logic                 col_phase;
        logic                 drive;
        logic                 rx_p;
        logic                 rx_n;
        logic                 col_p;
        logic                 col_n;
        logic                 fifo_rdy;
    } cmc_core_st_t;

    cmc_core_st_t           s_ff;
    cmc_core_st_t           nxt_s;
    logic [NSYNC-1:0]       pins;
    logic                   fifo_in_ready;
    logic [TXF_WIDTH-1:0]   fifo_dout;
    logic                   fifo_out_valid;
    logic                   pop;
    logic                   hb_en;
    logic                   jab_dis;
    logic                   burst_on;
    logic                   rx_act;
    logic                   rx_dat;

    localparam logic [JAB_CNT_W-1:0] JAB_ACT_LAST = JAB_CNT_W'(JAB_ACT_CYCLES - 1);
    localparam logic [JAB_CNT_W-1:0] JAB_REC_LAST = JAB_CNT_W'(JAB_REC_CYCLES - 1);
    localparam logic [HB_CNT_W-1:0]  HB_DLY_LAST  = HB_CNT_W'(HB_DELAY_CYC - 1);
    localparam logic [HB_CNT_W-1:0]  HB_LEN_LAST  = HB_CNT_W'(HB_LEN_CYC - 1);

    always_comb begin
        pins          = '0;
        pins[SY_TXA]  = tx_active_in;
        pins[SY_TXD]  = tx_data_in;
        pins[SY_RXA]  = cable_activity_in;
        pins[SY_RXD]  = cable_sense_in;
        pins[SY_COL]  = coll_below_thresh_in;
        pins[SY_DIS]  = cable_disconnect_in;
        pins[SY_HB]   = heartbeat_jabber_strap_in[STRAP_HB_BIT];
        pins[SY_JD]   = heartbeat_jabber_strap_in[STRAP_JD_BIT];
        pins[SY_DRDY] = drive_ready_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer: samples wait here while the cable driver stalls

    cmc_fifo #(
        .W     (TXF_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_txf (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_data_in    ({s_ff.filt[SY_TXA], s_ff.filt[SY_TXD]}),
        .in_valid_in   (1'b1),
        .in_ready_out  (fifo_in_ready),
        .out_data_out  (fifo_dout),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (s_ff.filt[SY_DRDY])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_s    = s_ff;
        pop      = fifo_out_valid && s_ff.filt[SY_DRDY];
        hb_en    = s_ff.filt[SY_HB];
        jab_dis  = s_ff.filt[SY_JD];

        // Three-stage sync; a level counts once the last two agree
        nxt_s.sync_a = pins;
        nxt_s.sync_b = s_ff.sync_a;
        nxt_s.sync_c = s_ff.sync_b;
        for (int i = 0; i < NSYNC; i++) begin
            if (s_ff.sync_b[i] == s_ff.sync_c[i]) begin
                nxt_s.filt[i] = s_ff.sync_c[i];
            end
        end

        // Stalled driver keeps the last sample rather than idling mid-frame
        if (pop) begin
            nxt_s.tx_on  = fifo_dout[TXF_ACT_BIT];
            nxt_s.tx_dat = fifo_dout[TXF_DAT_BIT];
        end

        // Jabber timer and lockup
        if (jab_dis) begin
            nxt_s.jabbed  = 1'b0;
            nxt_s.jab_cnt = '0;
            nxt_s.rec_cnt = '0;
        end else if (!s_ff.jabbed) begin
            if (!s_ff.tx_on) begin
                nxt_s.jab_cnt = '0;
            end else if (s_ff.jab_cnt == JAB_ACT_LAST) begin
                nxt_s.jabbed  = 1'b1;
                nxt_s.jab_cnt = '0;
                nxt_s.rec_cnt = '0;
            end else begin
                nxt_s.jab_cnt = s_ff.jab_cnt + 1'b1;
            end
        end else begin
            // Any transmit activity restarts the quiet interval
            if (s_ff.tx_on) begin
                nxt_s.rec_cnt = '0;
            end else if (s_ff.rec_cnt == JAB_REC_LAST) begin
                nxt_s.jabbed  = 1'b0;
                nxt_s.rec_cnt = '0;
                nxt_s.jab_cnt = '0;
            end else begin
                nxt_s.rec_cnt = s_ff.rec_cnt + 1'b1;
            end
        end

        // Cable switch follows data unchanged unless locked out
        nxt_s.drive = s_ff.tx_on && s_ff.tx_dat && !s_ff.jabbed;

        // Receive pair: own drive while sending, else the cable
        if (s_ff.tx_on) begin
            rx_act = 1'b1;
            rx_dat = s_ff.drive;
        end else begin
            rx_act = s_ff.filt[SY_RXA];
            rx_dat = s_ff.filt[SY_RXD];
        end
        nxt_s.rx_p = rx_act && rx_dat;
        nxt_s.rx_n = rx_act && !rx_dat;

        // Heartbeat sequencer
        unique case (s_ff.hb)
            HB_IDLE: begin
                nxt_s.hb_cnt = '0;
                if (s_ff.tx_on) begin
                    nxt_s.hb = HB_TX;
                end
            end
            HB_TX: begin
                nxt_s.hb_cnt = '0;
                if (!s_ff.tx_on) begin
                    // Strap alone decides; jabber-disable has no say
                    nxt_s.hb = hb_en ? HB_WAIT : HB_IDLE;
                end
            end
            HB_WAIT: begin
                if (s_ff.tx_on) begin
                    nxt_s.hb     = HB_TX;
                    nxt_s.hb_cnt = '0;
                end else if (s_ff.hb_cnt == HB_DLY_LAST) begin
                    nxt_s.hb     = HB_BURST;
                    nxt_s.hb_cnt = '0;
                end else begin
                    nxt_s.hb_cnt = s_ff.hb_cnt + 1'b1;
                end
            end
            HB_BURST: begin
                // Burst always runs to its full length
                if (s_ff.hb_cnt == HB_LEN_LAST) begin
                    nxt_s.hb     = HB_IDLE;
                    nxt_s.hb_cnt = '0;
                end else begin
                    nxt_s.hb_cnt = s_ff.hb_cnt + 1'b1;
                end
            end
        endcase

        // Collision pair: one clock high, one low gives 10 MHz
        burst_on = s_ff.filt[SY_COL] || s_ff.filt[SY_DIS]
                   || s_ff.jabbed || (s_ff.hb == HB_BURST);
        nxt_s.col_phase = burst_on && !s_ff.col_phase;
        nxt_s.col_p     = burst_on && !s_ff.col_phase;
        nxt_s.col_n     = burst_on && s_ff.col_phase;

        nxt_s.fifo_rdy = fifo_in_ready;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cable_drive_out          = s_ff.drive;
    assign receive_to_station_p_out = s_ff.rx_p;
    assign receive_to_station_n_out = s_ff.rx_n;
    assign collision_out_p_out      = s_ff.col_p;
    assign collision_out_n_out      = s_ff.col_n;
    assign tx_fifo_ready_out        = s_ff.fifo_rdy;
    assign jabber_lock_out          = s_ff.jabbed;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking core_cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    drive_polarity_a: assert property (
        s_ff.drive |-> $past(s_ff.tx_on) && $past(s_ff.tx_dat) && !$past(s_ff.jabbed))
        else $error("cable drive without matching transmit data");

    drive_follow_a: assert property (
        s_ff.tx_on && s_ff.tx_dat && !s_ff.jabbed |=> cable_drive_out)
        else $error("cable drive missing for transmit data");

    rx_follow_a: assert property (
        !s_ff.tx_on && s_ff.filt[SY_RXA] |=> receive_to_station_p_out == $past(s_ff.filt[SY_RXD])
            && receive_to_station_n_out == !$past(s_ff.filt[SY_RXD]))
        else $error("receive pair not following cable");

    rx_loopback_a: assert property (
        s_ff.tx_on |=> receive_to_station_p_out == $past(s_ff.drive)
            && receive_to_station_n_out != receive_to_station_p_out)
        else $error("loopback missing while transmitting");

    rx_idle_a: assert property (
        !s_ff.tx_on && !s_ff.filt[SY_RXA]
            |=> !receive_to_station_p_out && !receive_to_station_n_out)
        else $error("receive pair active with idle cable");

    jab_inhibit_a: assert property (
        s_ff.jabbed |=> !cable_drive_out)
        else $error("cable driven during jabber lockup");

    jab_trip_a: assert property (
        !s_ff.filt[SY_JD] && !s_ff.jabbed && s_ff.tx_on && s_ff.jab_cnt == JAB_ACT_LAST
            |=> s_ff.jabbed)
        else $error("jabber did not trip at activation count");

    jab_disable_a: assert property (
        s_ff.filt[SY_JD] |=> !s_ff.jabbed
            ##1 (cable_drive_out == $past(s_ff.tx_on && s_ff.tx_dat)))
        else $error("transmitter inhibited while jabber disabled");

    coll_burst_a: assert property (
        s_ff.filt[SY_COL] |=> collision_out_p_out != collision_out_n_out)
        else $error("no collision burst during collision");

    disc_burst_a: assert property (
        s_ff.filt[SY_DIS] |=> collision_out_p_out != collision_out_n_out)
        else $error("no collision burst while cable disconnected");

    jab_burst_a: assert property (
        s_ff.jabbed |=> collision_out_p_out || collision_out_n_out)
        else $error("no collision burst during jabber lockup");

    coll_quiet_a: assert property (
        !s_ff.filt[SY_COL] && !s_ff.filt[SY_DIS] && !s_ff.jabbed && s_ff.hb != HB_BURST
            |=> !collision_out_p_out && !collision_out_n_out)
        else $error("collision pair active without cause");

    coll_pair_a: assert property (
        !(collision_out_p_out && collision_out_n_out))
        else $error("both collision wires high");

    hb_start_a: assert property (
        $fell(s_ff.tx_on) && s_ff.hb == HB_TX && s_ff.filt[SY_HB] ##1 (!s_ff.tx_on)[*8]
            |-> ##[1:12] s_ff.hb == HB_BURST)
        else $error("heartbeat burst missing after transmit end");

    hb_strap_a: assert property (
        s_ff.hb == HB_TX && !s_ff.tx_on && !s_ff.filt[SY_HB] |=> s_ff.hb == HB_IDLE)
        else $error("heartbeat started with strap off");

    hb_jabdis_a: assert property (
        s_ff.hb == HB_TX && !s_ff.tx_on && s_ff.filt[SY_HB] && s_ff.filt[SY_JD]
            |=> s_ff.hb == HB_WAIT)
        else $error("heartbeat lost under jabber disable");

    hb_length_a: assert property (
        $fell(s_ff.hb == HB_BURST) |-> $past(s_ff.hb_cnt) == HB_LEN_LAST)
        else $error("heartbeat burst length wrong");

    hb_hold_a: assert property (
        s_ff.hb == HB_BURST && s_ff.hb_cnt != HB_LEN_LAST |=> s_ff.hb == HB_BURST)
        else $error("heartbeat burst cut short");

    hb_wait_a: assert property (
        s_ff.hb == HB_WAIT && !s_ff.tx_on && s_ff.hb_cnt != HB_DLY_LAST |=> s_ff.hb == HB_WAIT)
        else $error("heartbeat burst started early");

    pulse_width_a: assert property (
        collision_out_p_out |=> !collision_out_p_out)
        else $error("collision pulse high too long");

    jab_recover_a: assert property (
        $fell(s_ff.jabbed) && !$past(s_ff.filt[SY_JD]) |->
            $past(s_ff.rec_cnt) == JAB_REC_LAST && !$past(s_ff.tx_on) && s_ff.jab_cnt == '0)
        else $error("jabber released before quiet interval");

    jab_hold_a: assert property (
        s_ff.jabbed && s_ff.tx_on && !s_ff.filt[SY_JD] |=> s_ff.jabbed)
        else $error("lockup released during transmit activity");
endmodule

// ### core/cmc_pkg.sv
// Constants and types of the coax attachment unit control logic.
// Assumes a single 20 MHz clock and pins already reduced to logic levels.
package cmc_pkg;

    localparam int CLK_PERIOD_NS  = 50;
    // Heartbeat timing, least values rounded up
    localparam int HB_DELAY_NS    = 600;
    localparam int HB_LEN_NS      = 800;
    localparam int HB_DELAY_CYC   = (HB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HB_LEN_CYC     = (HB_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Collision pulse high time, one clock
    localparam int COL_HIGH_NS    = 50;
    // Jabber activation and recovery, least values
    localparam int JAB_ACT_MS     = 20;
    localparam int JAB_REC_MS     = 250;
    localparam int JAB_ACT_CYC    = JAB_ACT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int JAB_REC_CYC    = JAB_REC_MS * 1000000 / CLK_PERIOD_NS;
    localparam int JAB_CNT_W      = 24;
    localparam int HB_CNT_W       = 5;
    // Transmit path buffering
    localparam int TXF_WIDTH      = 2;
    localparam int TXF_DEPTH      = 16;
    localparam int TXF_ACT_BIT    = 1;
    localparam int TXF_DAT_BIT    = 0;
    // Synchroniser slots
    localparam int SY_TXA         = 0;
    localparam int SY_TXD         = 1;
    localparam int SY_RXA         = 2;
    localparam int SY_RXD         = 3;
    localparam int SY_COL         = 4;
    localparam int SY_DIS         = 5;
    localparam int SY_HB          = 6;
    localparam int SY_JD          = 7;
    localparam int SY_DRDY        = 8;
    localparam int NSYNC          = 9;
    localparam int STRAP_HB_BIT   = 0;
    localparam int STRAP_JD_BIT   = 1;

    typedef enum logic [1:0] {
        HB_IDLE  = 2'h0,
        HB_TX    = 2'h1,
        HB_WAIT  = 2'h3,
        HB_BURST = 2'h2
    } cmc_hb_t;

endpackage

// ### core/cmc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready_out is low while full.
`timescale 1ns/1ps
module cmc_fifo #(
    parameter int W     = 2,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // Fill side
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    // Drain side
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
    } cmc_fifo_st_t;

    cmc_fifo_st_t s_ff;
    cmc_fifo_st_t nxt_s;
    logic         push;
    logic         pop;

    assign in_ready_out  = (s_ff.count != (AW+1)'(DEPTH));
    assign out_valid_out = (s_ff.count != '0);
    assign out_data_out  = s_ff.mem[s_ff.rd_ptr];

    always_comb begin
        nxt_s = s_ff;
        push  = in_valid_in && in_ready_out;
        pop   = out_valid_out && out_ready_in;
        if (push) begin
            nxt_s.mem[s_ff.wr_ptr] = in_data_in;
            nxt_s.wr_ptr           = (s_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_s.rd_ptr = (s_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_ff.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            nxt_s.count = s_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_s.count = s_ff.count - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    default clocking fifo_cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    fifo_no_over_a: assert property (s_ff.count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    fifo_hold_a: assert property (out_valid_out && !out_ready_in && !push |=>
                                  out_valid_out && $stable(out_data_out))
        else $error("fifo head lost while stalled");
endmodule

// ### verif/cmc_station_model.sv
// Station end of the attachment interface: sends frames, watches the collision pair.
// Assumes a 20 MHz clk_in; send is called by the bench between clock edges.
`timescale 1ns/1ps
module cmc_station_model (
    // Clock
    input  wire logic clk_in,
    // Collision pair from the block
    input  wire logic col_p_in,
    input  wire logic col_n_in,
    // Transmit pair toward the block
    output logic      tx_active_out,
    output logic      tx_data_out
);
    int   cnt    = 0;
    int   len_r  = 0;
    int   ones_r = 0;
    int   pulses = 0;
    int   max_w  = 0;
    int   run    = 0;
    logic both   = 1'b0;

    initial begin
        tx_active_out = 1'b0;
        tx_data_out   = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Released pair toggles, so a stale level is never taken as data
    always @(posedge clk_in) begin
        #5;
        tx_active_out = (cnt < len_r);
        tx_data_out   = (cnt < len_r) ? (cnt < ones_r) : ~tx_data_out;
        if (cnt < len_r) begin
            cnt++;
        end
    end

    ////////////////////////////////////////////////////////////
    // Pulse count and longest high run on the positive wire
    always @(posedge clk_in) begin
        if (col_p_in) begin
            if (run == 0) begin
                pulses <= pulses + 1;
            end
            run   <= run + 1;
            max_w <= (run + 1 > max_w) ? run + 1 : max_w;
        end else begin
            run <= 0;
        end
        if (col_p_in && col_n_in) begin
            both <= 1'b1;
        end
    end

    task automatic clear();
        pulses = 0;
        max_w  = 0;
        both   = 1'b0;
    endtask

    // Parameters set mid-cycle so the driving process never races them
    task automatic send(input int len, input int ones);
        @(negedge clk_in);
        ones_r = ones;
        len_r  = len;
        cnt    = 0;
        wait (cnt == len_r);
        @(posedge clk_in);
        #5;
    endtask
endmodule

// ### verif/cmc_core_test.sv
// Self-checking bench of the coax attachment control logic.
// Assumes short jabber counts; station model drives the transmit pair.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("BAD %s expected %0d seen %0d", nm, e, g); \
    end \
end
module cmc_core_test
    import cmc_pkg::*;
;
    localparam int JAB_ACT = 64;
    localparam int JAB_REC = 128;
    logic       clk_in    = 1'b0;
    logic       sys_rst   = 1'b1;
    logic       sense     = 1'b0;
    logic       act       = 1'b0;
    logic       coll      = 1'b0;
    logic       disc      = 1'b0;
    logic       dready    = 1'b1;
    logic [1:0] strap     = 2'h1;
    logic       txa;
    logic       txd;
    logic       drv;
    logic       rp;
    logic       rn;
    logic       cp;
    logic       cn;
    logic       frdy;
    logic       lock;
    int         err_total = 0;
    int         checked   = 0;
    int         cyc       = 0;

    initial begin
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;

    cmc_station_model i_cmc_station_model (
        .clk_in        (clk_in),
        .col_p_in      (cp),
        .col_n_in      (cn),
        .tx_active_out (txa),
        .tx_data_out   (txd)
    );
    cmc_core #(
        .JAB_ACT_CYCLES (JAB_ACT),
        .JAB_REC_CYCLES (JAB_REC),
        .FIFO_DEPTH     (TXF_DEPTH)
    ) i_cmc_core (
        .clk_in                    (clk_in),
        .sys_rst_in                (sys_rst),
        .tx_active_in              (txa),
        .tx_data_in                (txd),
        .cable_sense_in            (sense),
        .cable_activity_in         (act),
        .coll_below_thresh_in      (coll),
        .cable_disconnect_in       (disc),
        .drive_ready_in            (dready),
        .cable_drive_out           (drv),
        .heartbeat_jabber_strap_in (strap),
        .receive_to_station_p_out  (rp),
        .receive_to_station_n_out  (rn),
        .collision_out_p_out       (cp),
        .collision_out_n_out       (cn),
        .tx_fifo_ready_out         (frdy),
        .jabber_lock_out           (lock)
    );

    ////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk_in);
        #5;
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Frame, then heartbeat delay from pin release and burst length
    task automatic frame(input int len, input int ones, output int nd, output int nr,
                         output int nl, output int dh, output int nb);
        int t_end;
        nd = 0;
        nr = 0;
        nl = 0;
        dh = -1;
        nb = 0;
        t_end = 0;
        i_cmc_station_model.clear();
        fork
            begin
                i_cmc_station_model.send(len, ones);
                t_end = cyc;
            end
            for (int i = 0; i < len + 12; i++) begin
                tick();
                nd += drv;
                nr += rp;
                nl += lock;
            end
        join
        for (int i = 0; i < 40 && dh < 0; i++) begin
            if (cp === 1'b1) dh = cyc - t_end;
            else tick();
        end
        repeat (40) begin
            nb += (cp | cn);
            tick();
        end
    endtask

    ////////////////////////////////////////////////////////////
    // Fewer ones than zeros, so an inverted drive cannot match
    task automatic t_heartbeat();
        int nd, nr, nl, dh, nb;
        strap = 2'h1;
        frame(16, 5, nd, nr, nl, dh, nb);
        `CHK("drive_highs", 5, nd)
        `CHK("loopback_highs", 5, nr)
        `CHK("hb_delay_ok", 1, int'(dh >= 12 && dh <= 28))
        `CHK("hb_len_ok", 1, int'(nb >= 16 && nb <= 30))
        `CHK("pulse_width", 1, i_cmc_station_model.max_w)
        `CHK("pair_overlap", 1'b0, i_cmc_station_model.both)
    endtask

    task automatic t_repeater();
        int nd, nr, nl, dh, nb;
        strap = 2'h0;
        frame(16, 16, nd, nr, nl, dh, nb);
        `CHK("rep_drive", 16, nd)
        `CHK("rep_no_hb", 0, nb)
        `CHK("rep_no_start", -1, dh)
    endtask

    task automatic t_jab_off();
        int nd, nr, nl, dh, nb;
        strap = 2'h3;
        frame(150, 150, nd, nr, nl, dh, nb);
        `CHK("long_drive", 150, nd)
        `CHK("long_no_lock", 0, nl)
        `CHK("long_hb_ok", 1, int'(dh >= 12 && dh <= 28))
        `CHK("long_hb_len", 1, int'(nb >= 16 && nb <= 30))
    endtask

    task automatic t_jabber();
        int nd;
        strap = 2'h1;
        nd = 0;
        i_cmc_station_model.clear();
        fork
            i_cmc_station_model.send(150, 150);
            for (int i = 0; i < 160; i++) begin
                tick();
                nd += drv;
            end
        join
        `CHK("jab_cut_ok", 1, int'(nd >= JAB_ACT && nd <= JAB_ACT + 2))
        `CHK("jab_lock", 1'b1, lock)
        `CHK("jab_coll_ok", 1, int'(i_cmc_station_model.pulses > 8))
        repeat (100) tick();
        `CHK("jab_hold", 1'b1, lock)
        repeat (60) tick();
        `CHK("jab_release", 1'b0, lock)
        `CHK("jab_quiet", 1'b0, cp | cn)
    endtask

    // Reset in mid-frame after a trip: lockup and its timer must both clear
    task automatic t_reset();
        int nd;
        strap = 2'h1;
        nd = 0;
        fork
            i_cmc_station_model.send(100, 100);
            begin
                repeat (80) tick();
                sys_rst = 1'b1;
                tick();
                `CHK("rst_lock", 1'b0, lock)
                `CHK("rst_out", 1'b0, drv | cp | cn)
                sys_rst = 1'b0;
                repeat (25) begin
                    tick();
                    nd += drv;
                end
            end
        join
        `CHK("rst_rearmed", 1, int'(nd > 0))
        `CHK("rst_no_lock", 1'b0, lock)
    endtask

    task automatic t_collision();
        int np, nn;
        for (int k = 0; k < 2; k++) begin
            np = 0;
            nn = 0;
            i_cmc_station_model.clear();
            coll = (k == 0);
            disc = (k == 1);
            for (int i = 0; i < 30; i++) begin
                tick();
                np += cp;
                nn += cn;
                if (i == 19) begin
                    coll = 1'b0;
                    disc = 1'b0;
                end
            end
            `CHK("coll_p_ok", 1, int'(np >= 9 && np <= 11))
            `CHK("coll_n_ok", 1, int'(nn >= 9 && nn <= 11))
            `CHK("coll_width", 1, i_cmc_station_model.max_w)
            `CHK("coll_overlap", 1'b0, i_cmc_station_model.both)
            `CHK("coll_stop", 1'b0, cp | cn)
        end
    endtask

    // Cable toggles once idle, so a stale level cannot leak through
    task automatic t_receive();
        int np, nn;
        np = 0;
        nn = 0;
        for (int i = 0; i < 24; i++) begin
            act = (i < 12);
            sense = (i < 12) ? (i < 4) : ~sense;
            tick();
            np += rp;
            nn += rn;
        end
        `CHK("rx_p_ok", 1, int'(np >= 3 && np <= 5))
        `CHK("rx_n_ok", 1, int'(nn >= 7 && nn <= 9))
        `CHK("rx_idle", 1'b0, rp | rn)
    endtask

    task automatic t_fifo();
        int nd, nf;
        strap = 2'h1;
        nd = 0;
        nf = 0;
        dready = 1'b0;
        fork
            i_cmc_station_model.send(24, 24);
            for (int i = 0; i < 30; i++) begin
                tick();
                nd += drv;
                nf += !frdy;
            end
        join
        `CHK("stall_drive", 0, nd)
        `CHK("fifo_full_seen", 1, int'(nf > 0))
        dready = 1'b1;
        nd = 0;
        repeat (30) begin
            tick();
            nd += drv;
        end
        `CHK("drained_ok", 1, int'(nd >= 1 && nd < TXF_DEPTH))
        `CHK("fifo_ready", 1'b1, frdy)
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        #5;
        sys_rst = 1'b0;
        tick();
        `CHK("init_lock", 1'b0, lock)
        `CHK("init_pairs", 1'b0, cp | cn | rp | rn)
        `CHK("init_fifo", 1'b1, frdy)
        t_heartbeat();
        t_repeater();
        t_jab_off();
        repeat (60) tick();
        t_jabber();
        repeat (60) tick();
        t_reset();
        repeat (60) tick();
        t_collision();
        t_receive();
        t_fifo();
        repeat (60) tick();
        report_and_stop();
    end

    // Whole run is about 1200 cycles
    initial begin
        repeat (4000) @(posedge clk_in);
        err_total++;
        $display("BAD watchdog expected 0 seen 1");
        report_and_stop();
    end
endmodule
